// ==== hw/strobe_delay_block.sv ====
/*
 * Strobe delay block: digital model of read strobe shift, write clock
 * phase generation, leveling delay, margin stepping and FIFO pointers.
 * Assumes the strobe and edge clock are sampled by pclk, which is well
 * faster than both in the bench; delays are tap counts on pclk.
 */
`timescale 1ns/1ns
// How it works
// - The memory strobe is delayed before read data capture uses it.
// - Read delay follows the master loop code, giving a quarter-period shift.
// - A write delay line derives the data and strobe write clocks.
// - Strobe write clock plus a data write clock lagging by 90 degrees.
// - Leveling delay taps come from the 8-bit leveling input.
// - Separate load, step and direction inputs adjust read and write delays.
// - Limit flags rise when an adjusted delay reaches its maximum.
// - Three-bit FIFO write and read pointers cross strobe to edge clock.
// - While paused the write clocks hold and write steps are ignored; a write load still sets the write tap and limit.
// - Read indication and pulse selection frame reads; burst seen reported.
// - A valid pulse marks the start of read data toward the core.
module strobe_delay_block
    import strobe_delay_pkg::*;
(
    // APB
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [7:0]                  paddr,
    input  wire logic [31:0]                 pwdata,
    output logic      [31:0]                 prdata,
    output logic                             pready,
    output logic                             pslverr,
    // Link pins
    input  wire logic                        dqs_pin,
    input  wire logic                        edge_clock,
    // Controller
    input  wire strobe_delay_pkg::margin_t     read_margin,
    input  wire strobe_delay_pkg::margin_t     write_margin,
    input  wire strobe_delay_pkg::read_frame_t read_frame,
    input  wire logic                        pause,
    input  wire logic [7:0]                  leveling_delay,
    input  wire logic [7:0]                  dll_delay_code,
    // Outputs
    output logic                             read_strobe_shifted,
    output logic                             write_strobe_clock,
    output logic                             write_data_clock,
    output logic      [2:0]                  fifo_read_pointer,
    output logic      [2:0]                  fifo_write_pointer,
    output logic                             read_valid_start,
    output logic                             burst_seen,
    output logic                             read_margin_limit,
    output logic                             write_margin_limit,
    output logic                             irq
);
    import strobe_delay_pkg::*;

    // Synchronisers for pins and the two margin step inputs from other domains
    logic [1:0] dqs_s_r, edge_clock_s_r;
    logic [1:0] rstep_s_r, wstep_s_r;
    logic       dqs_d_r, edge_clock_d_r, rstep_d_r, wstep_d_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            dqs_s_r   <= 2'h0;
            edge_clock_s_r  <= 2'h0;
            rstep_s_r <= 2'h0;
            wstep_s_r <= 2'h0;
            dqs_d_r   <= 1'b0;
            edge_clock_d_r  <= 1'b0;
            rstep_d_r <= 1'b0;
            wstep_d_r <= 1'b0;
        end else begin
            dqs_s_r   <= {dqs_s_r[0], dqs_pin};
            edge_clock_s_r  <= {edge_clock_s_r[0], edge_clock};
            rstep_s_r <= {rstep_s_r[0], read_margin.step};
            wstep_s_r <= {wstep_s_r[0], write_margin.step};
            dqs_d_r   <= dqs_s_r[1];
            edge_clock_d_r  <= edge_clock_s_r[1];
            rstep_d_r <= rstep_s_r[1];
            wstep_d_r <= wstep_s_r[1];
        end
    end

    logic dqs_rise, edge_clock_rise, rstep_pulse, wstep_pulse;
    assign dqs_rise    = dqs_s_r[1] & ~dqs_d_r;
    assign edge_clock_rise   = edge_clock_s_r[1] & ~edge_clock_d_r;
    assign rstep_pulse = rstep_s_r[1] & ~rstep_d_r;
    assign wstep_pulse = wstep_s_r[1] & ~wstep_d_r;

    // Registers
    logic [1:0] ctrl_r;
    logic [7:0] dll_code_r;
    logic [3:0] irq_stat_r, irq_mask_r;
    logic [7:0] rd_tap_r, wr_tap_r;

    // Saturating one-tap step
    function automatic logic [7:0] step_tap(input logic [7:0] tap, input logic dir);
        if (dir)
            step_tap = (tap == TAP_MAX) ? tap : tap + 8'h01;
        else
            step_tap = (tap == 8'h00) ? tap : tap - 8'h01;
    endfunction

    // Effective DLL code: pin unless software override selected
    logic [7:0] code_eff;
    assign code_eff = ctrl_r[CTRL_LOOPBACK] ? dll_code_r : dll_delay_code;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rd_tap_r <= DLL_CODE_RST;
        else if (!read_margin.load_n)
            rd_tap_r <= code_eff;
        else if (rstep_pulse)
            rd_tap_r <= step_tap(rd_tap_r, read_margin.dir);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wr_tap_r <= DLL_CODE_RST;
        else if (!write_margin.load_n)
            wr_tap_r <= code_eff;
        else if (wstep_pulse && !pause)
            wr_tap_r <= step_tap(wr_tap_r, write_margin.dir);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_margin_limit  <= 1'b0;
            write_margin_limit <= 1'b0;
        end else begin
            read_margin_limit  <= (rd_tap_r == TAP_MAX);
            write_margin_limit <= (wr_tap_r == TAP_MAX);
        end
    end

    // Read delay line: sampled strobe replayed rd_tap plus two cycles later.
    // A flop chain, not a counter, so every edge of a burst survives.
    logic [255:0] rd_line_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rd_line_r <= '0;
        else
            rd_line_r <= {rd_line_r[254:0], dqs_s_r[1]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            read_strobe_shifted <= 1'b0;
        else
            read_strobe_shifted <= rd_line_r[rd_tap_r];
    end

    // Write delay line: edge clock delayed by write plus leveling taps;
    // the data clock lags by a further quarter period, the loop's code
    logic [8:0]    wr_total;
    logic [9:0]    wd_total;
    logic [1023:0] wr_line_r;
    assign wr_total = {1'b0, wr_tap_r} + {1'b0, leveling_delay};
    assign wd_total = {1'b0, wr_total} + {2'b00, code_eff};

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wr_line_r <= '0;
        else
            wr_line_r <= {wr_line_r[1022:0], edge_clock_s_r[1]};
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            write_strobe_clock <= 1'b0;
            write_data_clock   <= 1'b0;
        end else if (pause) begin
            write_strobe_clock <= write_strobe_clock;
            write_data_clock   <= write_data_clock;
        end else begin
            write_strobe_clock <= wr_line_r[wr_total];
            write_data_clock   <= wr_line_r[wd_total];
        end
    end

    // FIFO pointers: write on strobe, read on edge clock, gray coded
    logic [2:0] wbin_r, rbin_r;
    logic       read_on;
    assign read_on = |read_frame.read_ind;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            wbin_r <= PTR_RST;
        else if (dqs_rise && ctrl_r[CTRL_ENABLE])
            wbin_r <= wbin_r + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            rbin_r <= PTR_RST;
        else if (edge_clock_rise && ctrl_r[CTRL_ENABLE] && rbin_r != wbin_r)
            rbin_r <= rbin_r + 3'h1;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fifo_write_pointer <= PTR_RST;
            fifo_read_pointer  <= PTR_RST;
        end else begin
            fifo_write_pointer <= wbin_r ^ (wbin_r >> 1);
            fifo_read_pointer  <= rbin_r ^ (rbin_r >> 1);
        end
    end

    // Read framing: count strobe edges while read is indicated
    logic [2:0] burst_cnt_r;
    logic       read_on_d_r;
    logic       burst_evt, valid_evt;
    assign valid_evt = read_on && dqs_rise && burst_cnt_r == 3'h0;
    assign burst_evt = read_on && dqs_rise &&
                       burst_cnt_r == {1'b0, read_frame.pulse_sel} + 3'h1;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            burst_cnt_r <= 3'h0;
            read_on_d_r <= 1'b0;
        end else begin
            read_on_d_r <= read_on;
            if (!read_on)
                burst_cnt_r <= 3'h0;
            else if (dqs_rise && burst_cnt_r != 3'h7)
                burst_cnt_r <= burst_cnt_r + 3'h1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            read_valid_start <= 1'b0;
            burst_seen       <= 1'b0;
        end else begin
            read_valid_start <= valid_evt;
            if (read_on && !read_on_d_r)
                burst_seen <= 1'b0;
            else if (burst_evt)
                burst_seen <= 1'b1;
        end
    end

    // APB: zero wait states
    logic wr_en, rd_en;
    assign wr_en   = psel & penable & pwrite;
    assign rd_en   = psel & ~pwrite;
    assign pready  = 1'b1;
    assign pslverr = 1'b0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r     <= 2'h1;
            dll_code_r <= DLL_CODE_RST;
            irq_mask_r <= IRQ_MASK_RST;
        end else if (wr_en) begin
            if (paddr == CTRL_OFS)
                ctrl_r <= pwdata[1:0];
            if (paddr == DLL_CODE_OFS)
                dll_code_r <= pwdata[7:0];
            if (paddr == IRQ_MASK_OFS)
                irq_mask_r <= pwdata[3:0];
        end
    end

    // Sticky events; a set in the clearing cycle wins
    logic [3:0] evt;
    logic [3:0] clr;
    logic       rlim_d_r, wlim_d_r;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rlim_d_r <= 1'b0;
            wlim_d_r <= 1'b0;
        end else begin
            rlim_d_r <= read_margin_limit;
            wlim_d_r <= write_margin_limit;
        end
    end
    assign evt = {valid_evt, burst_evt,
                  write_margin_limit & ~wlim_d_r, read_margin_limit & ~rlim_d_r};
    assign clr = (wr_en && paddr == IRQ_STAT_OFS) ? pwdata[3:0] : 4'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            irq_stat_r <= 4'h0;
        else
            irq_stat_r <= (irq_stat_r & ~clr) | evt;
    end
    assign irq = |(irq_stat_r & irq_mask_r);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            prdata <= 32'h0000_0000;
        else if (rd_en && !penable) begin
            unique case (paddr)
                CTRL_OFS:     prdata <= {30'h0000_0000, ctrl_r};
                DLL_CODE_OFS: prdata <= {24'h00_0000, dll_code_r};
                TAPS_OFS:     prdata <= {16'h0000, wr_tap_r, rd_tap_r};
                STATUS_OFS:   prdata <= {27'h000_0000, pause, burst_seen,
                                         read_strobe_shifted,
                                         write_margin_limit, read_margin_limit};
                IRQ_STAT_OFS: prdata <= {28'h000_0000, irq_stat_r};
                IRQ_MASK_OFS: prdata <= {28'h000_0000, irq_mask_r};
                POINTERS_OFS: prdata <= {26'h000_0000, fifo_write_pointer,
                                         fifo_read_pointer};
                default:      prdata <= 32'h0000_0000;
            endcase
        end
    end

endmodule // strobe_delay_block

// ==== hw/strobe_delay_pkg.sv ====
/*
 * Package for the strobe delay block: register map, field positions,
 * reset values, tap limits and pin carriers.
 * Assumes a 32-bit APB slave on pclk at 20 MHz.
 */
package strobe_delay_pkg;

    // Register byte offsets
    localparam logic [7:0] CTRL_OFS      = 8'h00;
    localparam logic [7:0] DLL_CODE_OFS  = 8'h04;
    localparam logic [7:0] TAPS_OFS      = 8'h08;
    localparam logic [7:0] STATUS_OFS    = 8'h0C;
    localparam logic [7:0] IRQ_STAT_OFS  = 8'h10;
    localparam logic [7:0] IRQ_MASK_OFS  = 8'h14;
    localparam logic [7:0] POINTERS_OFS  = 8'h18;

    // Reset values and tap limit
    localparam logic [7:0] DLL_CODE_RST  = 8'h20;
    localparam logic [7:0] TAP_MAX       = 8'hFF;
    localparam logic [3:0] IRQ_MASK_RST  = 4'h0;

    // Interrupt status bit positions
    localparam int IRQ_RD_LIMIT  = 0;
    localparam int IRQ_WR_LIMIT  = 1;
    localparam int IRQ_BURST     = 2;
    localparam int IRQ_VALID     = 3;

    // Control register bit positions
    localparam int CTRL_ENABLE   = 0;
    localparam int CTRL_LOOPBACK = 1;

    // FIFO pointer reset; margin words: load_n above step above dir
    localparam logic [2:0] PTR_RST = 3'h0;

    typedef struct packed {
        logic       load_n;
        logic       step;
        logic       dir;
    } margin_t;

    typedef struct packed {
        logic [1:0] read_ind;
        logic [1:0] pulse_sel;
    } read_frame_t;

endpackage

// ==== dv/strobe_delay_asserts.sv ====
/* Port checker for the strobe delay block, bound into every instance.
   Assumes one pclk domain with presetn as its async reset. */
`timescale 1ns/1ns
module strobe_delay_asserts
    import strobe_delay_pkg::*;
(
    // Clock, reset and bus answer
    input wire logic                          pclk,
    input wire logic                          presetn,
    input wire logic                          pready,
    input wire logic                          pslverr,
    // Controller inputs
    input wire strobe_delay_pkg::margin_t     read_margin,
    input wire strobe_delay_pkg::margin_t     write_margin,
    input wire strobe_delay_pkg::read_frame_t read_frame,
    input wire logic                          pause,
    input wire logic [7:0]                    dll_delay_code,
    // Block outputs
    input wire logic                          write_strobe_clock,
    input wire logic                          write_data_clock,
    input wire logic [2:0]                    fifo_read_pointer,
    input wire logic [2:0]                    fifo_write_pointer,
    input wire logic                          read_valid_start,
    input wire logic                          read_margin_limit,
    input wire logic                          write_margin_limit
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_bus_ok; pready && !pslverr; endproperty
    a_bus_ok: assert property (p_bus_ok) else $error("bus answer not ready");
    property p_rd_load; (!read_margin.load_n && dll_delay_code != 8'hFF) [*6] |-> !read_margin_limit; endproperty
    a_rd_load: assert property (p_rd_load) else $error("read limit after load");
    property p_wr_load; (!write_margin.load_n && dll_delay_code != 8'hFF) [*6] |-> !write_margin_limit; endproperty
    a_wr_load: assert property (p_wr_load) else $error("write limit after load");
    property p_pause_hold; pause [*4] |=> $stable({write_strobe_clock, write_data_clock}); endproperty
    a_pause_hold: assert property (p_pause_hold) else $error("write clocks moved");
    property p_pause_lim; pause [*8] |=> $stable(write_margin_limit); endproperty
    a_pause_lim: assert property (p_pause_lim) else $error("write limit moved");
    property p_valid_pulse; read_valid_start |=> !read_valid_start; endproperty
    a_valid_pulse: assert property (p_valid_pulse) else $error("valid too long");
    property p_valid_idle; (read_frame.read_ind == 2'b00) [*8] |-> !read_valid_start; endproperty
    a_valid_idle: assert property (p_valid_idle) else $error("valid outside read");
    property p_wptr_gray; $countones(fifo_write_pointer ^ $past(fifo_write_pointer)) <= 1; endproperty
    a_wptr_gray: assert property (p_wptr_gray) else $error("write pointer jump");
    property p_rptr_gray; $countones(fifo_read_pointer ^ $past(fifo_read_pointer)) <= 1; endproperty
    a_rptr_gray: assert property (p_rptr_gray) else $error("read pointer jump");
endmodule // strobe_delay_asserts

bind strobe_delay_block strobe_delay_asserts u_chk (
    .pclk, .presetn, .pready, .pslverr, .read_margin, .write_margin, .read_frame,
    .pause, .dll_delay_code, .write_strobe_clock, .write_data_clock,
    .fifo_read_pointer, .fifo_write_pointer, .read_valid_start,
    .read_margin_limit, .write_margin_limit
);

// ==== dv/strobe_source.sv ====
/* Partner model: memory strobe bursts and a free running edge clock.
   Assumes the bench sets the edge count before it pulses go. */
`timescale 1ns/1ns
module strobe_source (
    // Bench control
    input  wire logic       go,
    input  wire logic [3:0] n_edges,
    // Link pins
    output logic            dqs_pin,
    output logic            edge_clock
);
    // Phase offset keeps it unrelated to pclk
    initial begin
        edge_clock = 1'b0;
        #137;
        forever #200 edge_clock = ~edge_clock;
    end
    // Parked low between bursts, like a terminated strobe
    initial dqs_pin = 1'b0;
    always @(posedge go) begin
        repeat (n_edges) begin
            #200 dqs_pin = 1'b1;
            #200 dqs_pin = 1'b0;
        end
    end
endmodule // strobe_source

// ==== dv/tb.sv ====
/* Bench for the strobe delay block: registers, strobe bursts, margins.
   Assumes the strobe_source partner and the bound port checker. */
`timescale 1ns/1ns
module tb;
    import strobe_delay_pkg::*;
    logic        pclk, presetn, psel, penable, pwrite, pause, go;
    logic        pready, pslverr, read_strobe_shifted, write_strobe_clock;
    logic        write_data_clock, read_valid_start, burst_seen, irq;
    logic        read_margin_limit, write_margin_limit;
    logic [7:0]  paddr, leveling_delay, dll_delay_code;
    logic [31:0] pwdata, prdata, q;
    logic [2:0]  fifo_read_pointer, fifo_write_pointer;
    logic [3:0]  nb;
    wire         dqs_pin, edge_clock;
    margin_t     read_margin, write_margin;
    read_frame_t read_frame;
    int          num_errors, n_checks, n_valid, k, t, c, p;

    strobe_delay_block i_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .dqs_pin, .edge_clock, .read_margin,
        .write_margin, .read_frame, .pause, .leveling_delay, .dll_delay_code,
        .read_strobe_shifted, .write_strobe_clock, .write_data_clock,
        .fifo_read_pointer, .fifo_write_pointer, .read_valid_start, .burst_seen,
        .read_margin_limit, .write_margin_limit, .irq);
    strobe_source i_src (.go(go), .n_edges(nb), .dqs_pin(dqs_pin), .edge_clock(edge_clock));

    initial pclk = 1'b0;
    always #25 pclk = ~pclk;
    always @(posedge pclk) if (read_valid_start === 1'b1) n_valid++;

    task wrap_up;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("ERROR %0t %s: got %h exp %h", $time, what, got, exp);
        end
    endtask
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            num_errors++;
            $display("ERROR %0t bus timeout", $time);
            wrap_up();
        end
        q = prdata;
        psel    <= 1'b0;
        penable <= 1'b0;
        // One idle edge so a following call never reassigns psel at once
        @(posedge pclk);
    endtask
    task rchk(input logic [7:0] a, input logic [31:0] exp, input string what);
        apb(1'b0, a, 32'h0000_0000);
        chk(q, exp, what);
    endtask
    // Step held 4 cycles each way, above the synchroniser minimum
    task step(input logic r, input logic w, input logic up);
        read_margin.step  <= r;
        write_margin.step <= w;
        read_margin.dir   <= up;
        write_margin.dir  <= up;
        repeat (4) @(posedge pclk);
        read_margin.step  <= 1'b0;
        write_margin.step <= 1'b0;
        repeat (4) @(posedge pclk);
    endtask
    task burst(input logic [3:0] n);
        nb <= n;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        repeat (8 * n + 12) @(posedge pclk);
    endtask
    task toggles(output int cnt);
        logic [1:0] last;
        cnt = 0;
        last = {write_strobe_clock, write_data_clock};
        repeat (40) begin
            @(posedge pclk);
            if ({write_strobe_clock, write_data_clock} !== last) cnt++;
            last = {write_strobe_clock, write_data_clock};
        end
    endtask

    initial begin
        {presetn, psel, penable, pwrite, pause, go} = 6'b0;
        {paddr, pwdata, nb} = '0;
        read_margin = 3'b100;
        write_margin = 3'b100;
        read_frame = '0;
        leveling_delay = 8'h04;
        dll_delay_code = 8'h30;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rchk(CTRL_OFS, 32'h0000_0001, "ctrl reset");
        rchk(TAPS_OFS, 32'h0000_2020, "taps reset");
        rchk(IRQ_MASK_OFS, {28'h000_0000, IRQ_MASK_RST}, "mask reset");
        rchk(DLL_CODE_OFS, {24'h00_0000, DLL_CODE_RST}, "code reset");
        apb(1'b1, DLL_CODE_OFS, 32'h0000_005A);
        rchk(DLL_CODE_OFS, 32'h0000_005A, "code write");
        apb(1'b1, 8'h40, 32'hFFFF_FFFF);
        rchk(8'h40, 32'h0000_0000, "unmapped");
        $display("test registers done");
        pause <= 1'b1;
        step(1'b1, 1'b1, 1'b1);
        rchk(TAPS_OFS, 32'h0000_2021, "paused step");
        toggles(t);
        chk(t, 0, "paused clocks");
        pause <= 1'b0;
        leveling_delay <= 8'h10;
        step(1'b0, 1'b1, 1'b1);
        rchk(TAPS_OFS, 32'h0000_2121, "write step");
        toggles(t);
        chk(t > 0, 1, "write clocks run");
        $display("test write side done");
        nb <= 4'd1;
        go <= 1'b1;
        @(posedge pclk);
        go <= 1'b0;
        for (k = 0; k < 20 && dqs_pin !== 1'b1; k++) @(posedge pclk);
        for (t = 0; t < 300 && read_strobe_shifted !== 1'b1; t++) @(posedge pclk);
        chk(t >= 33 && t <= 40, 1, "strobe shift");
        repeat (60) @(posedge pclk);
        $display("test strobe shift done");
        for (p = 0; p < 4; p++) begin
            c = n_valid;
            read_frame <= '{read_ind: 2'(p % 3 + 1), pulse_sel: 2'(p)};
            repeat (4) @(posedge pclk);
            burst(4'(p + 1));
            chk(burst_seen, 0, "burst early");
            burst(4'd1);
            chk(burst_seen, 1, "burst seen");
            chk(n_valid - c, 1, "valid start");
            read_frame <= '0;
            repeat (10) @(posedge pclk);
        end
        $display("test bursts done");
        rchk(IRQ_STAT_OFS, 32'h0000_000C, "read events");
        chk(irq, 0, "masked irq");
        apb(1'b1, IRQ_MASK_OFS, 32'h0000_0008);
        @(posedge pclk);
        chk(irq, 1, "unmasked irq");
        apb(1'b1, IRQ_STAT_OFS, 32'h0000_0008);
        @(posedge pclk);
        chk(irq, 0, "cleared irq");
        rchk(IRQ_STAT_OFS, 32'h0000_0004, "one clear");
        apb(1'b1, IRQ_MASK_OFS, 32'h0000_0003);
        $display("test interrupts done");
        repeat (221) step(1'b1, 1'b1, 1'b1);
        chk({read_margin_limit, write_margin_limit}, 2'b00, "below max");
        step(1'b1, 1'b1, 1'b1);
        chk({read_margin_limit, write_margin_limit, irq}, 3'b111, "at max");
        step(1'b1, 1'b1, 1'b1);
        rchk(TAPS_OFS, 32'h0000_FFFF, "saturate");
        step(1'b1, 1'b1, 1'b0);
        rchk(TAPS_OFS, 32'h0000_FEFE, "step down");
        chk({read_margin_limit, write_margin_limit}, 2'b00, "left max");
        read_margin.load_n  <= 1'b0;
        write_margin.load_n <= 1'b0;
        repeat (8) @(posedge pclk);
        read_margin.load_n  <= 1'b1;
        write_margin.load_n <= 1'b1;
        rchk(TAPS_OFS, 32'h0000_3030, "load");
        rchk(IRQ_STAT_OFS, 32'h0000_0007, "limit events");
        $display("test margins done");
        wrap_up();
    end
endmodule // tb
